/* File: bsd_pkg.sv */
// Package: descriptor field layout, register map and shared types
package bsd_pkg;
  // Register word width on the plain register port
  localparam int unsigned RegW = 32;
  // Register byte offsets (byte address = 4 * register index)
  localparam logic [7:0] OffDw0 = 8'h00;
  localparam logic [7:0] OffDw1 = 8'h04;
  localparam logic [7:0] OffDw2 = 8'h08;
  localparam logic [7:0] OffCtrl = 8'h0c;
  localparam logic [7:0] OffTok = 8'h10;
  localparam logic [7:0] OffStat = 8'h14;
  // Field positions in the 96-bit descriptor (DW2:DW1:DW0)
  localparam int unsigned ValidBit = 0;
  localparam int unsigned BytesLo = 3;
  localparam int unsigned BytesHi = 17;
  localparam int unsigned MpsLo = 18;
  localparam int unsigned MpsHi = 28;
  localparam int unsigned EpLsb = 31;
  localparam int unsigned EpHiLo = 32;
  localparam int unsigned EpHiHi = 34;
  localparam int unsigned DevLo = 35;
  localparam int unsigned DevHi = 41;
  localparam int unsigned PidLo = 42;
  localparam int unsigned PidHi = 43;
  localparam int unsigned KindLo = 44;
  localparam int unsigned KindHi = 45;
  localparam int unsigned SplitBit = 46;
  localparam int unsigned SpeedLo = 48;
  localparam int unsigned SpeedHi = 49;
  localparam int unsigned PortLo = 50;
  localparam int unsigned PortHi = 56;
  localparam int unsigned HubLo = 57;
  localparam int unsigned HubHi = 63;
  localparam int unsigned OffsLo = 72;
  localparam int unsigned OffsHi = 87;
  localparam int unsigned ReloadLo = 89;
  localparam int unsigned ReloadHi = 92;
  // Processor window base and word size of the payload memory
  localparam logic [17:0] MemBase = 18'h00400;
  localparam int unsigned MemWordBytes = 8;
  // Full-speed packet size ceiling
  localparam logic [10:0] FsMaxPacket = 11'h040;
  // Encodings
  localparam logic [1:0] KindControl = 2'h0;
  localparam logic [1:0] KindBulk = 2'h2;
  localparam logic [1:0] SpeedLow = 2'h2;
  localparam logic [1:0] SpeedFull = 2'h0;
  // Token codes
  typedef enum logic [1:0] {
    PidOut = 2'h0,
    PidIn = 2'h1,
    PidSetup = 2'h2,
    PidBad = 2'h3
  } bsd_pid_t;
  // Handshake outcomes reported by the transaction engine
  typedef enum logic [1:0] {
    ResNone = 2'h0,
    ResAck = 2'h1,
    ResNak = 2'h2,
    ResFatal = 2'h3
  } bsd_res_t;
  // Decoded descriptor fields
  typedef struct packed {
    logic [6:0] hubAddr;
    logic [6:0] hubPortIndex;
    logic [1:0] splitSpeedCode;
    logic split;
    logic lowSpeed;
    logic [1:0] endpointKind;
    logic kindOk;
    bsd_pid_t pid;
    logic [6:0] devAddr;
    logic [3:0] endpointNumber;
    logic [10:0] maxPacketSize;
    logic mpsOk;
    logic [14:0] transferByteTotal;
    logic [15:0] payloadBufferOffset;
    logic [3:0] reloadCount;
  } bsd_dec_t;
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [RegW-1:0] wdata;
    logic wr;
    logic rd;
  } bsd_req_t;
endpackage

/* File: bsd_addr_conv.sv */
// Processor byte address to payload memory word address converter
`timescale 1ns/1ps
`default_nettype none
module bsd_addr_conv (
  input wire logic [17:0] cpuAddr,
  output logic [15:0] wordAddr,
  output logic inWindow
);
  logic [17:0] rel;
  // R4 byte to word
  // Subtract window base, then divide by the word size
  always_comb begin
    rel = cpuAddr - bsd_pkg::MemBase;
    // Top bit stays zero: an 18-bit byte span holds only 15 bits of words
    wordAddr = {1'b0, rel[17:3]};
    inWindow = (cpuAddr >= bsd_pkg::MemBase);
  end
endmodule
`default_nettype wire

/* File: bsd_field_decode.sv */
// Pure field decoder for the lower three descriptor words
`timescale 1ns/1ps
`default_nettype none
module bsd_field_decode (
  input wire logic [95:0] desc,
  output var bsd_pkg::bsd_dec_t dec
);
  // Reserved bits are never looked at
  always_comb begin
    dec = '0;
    // R6 split select
    dec.split = desc[bsd_pkg::SplitBit];
    // R5 hub routing fields
    // R15 ignored without split
    if (dec.split) begin
      dec.hubAddr = desc[bsd_pkg::HubHi:bsd_pkg::HubLo];
      dec.hubPortIndex = desc[bsd_pkg::PortHi:bsd_pkg::PortLo];
      // R13 speed code
      dec.splitSpeedCode = desc[bsd_pkg::SpeedHi:bsd_pkg::SpeedLo];
      dec.lowSpeed = (dec.splitSpeedCode == bsd_pkg::SpeedLow);
    end
    // R7 endpoint kind
    dec.endpointKind = desc[bsd_pkg::KindHi:bsd_pkg::KindLo];
    dec.kindOk = (dec.endpointKind == bsd_pkg::KindControl) ||
                 (dec.endpointKind == bsd_pkg::KindBulk);
    // R8 token pid
    dec.pid = bsd_pkg::bsd_pid_t'(desc[bsd_pkg::PidHi:bsd_pkg::PidLo]);
    // R9 device and endpoint
    dec.devAddr = desc[bsd_pkg::DevHi:bsd_pkg::DevLo];
    dec.endpointNumber = {desc[bsd_pkg::EpHiHi:bsd_pkg::EpHiLo], desc[bsd_pkg::EpLsb]};
    // R10 packet size limit
    dec.maxPacketSize = desc[bsd_pkg::MpsHi:bsd_pkg::MpsLo];
    dec.mpsOk = !(dec.split && !dec.lowSpeed) || (dec.maxPacketSize <= bsd_pkg::FsMaxPacket);
    // R11 byte total
    dec.transferByteTotal = desc[bsd_pkg::BytesHi:bsd_pkg::BytesLo];
    // R4 word offset
    dec.payloadBufferOffset = desc[bsd_pkg::OffsHi:bsd_pkg::OffsLo];
    dec.reloadCount = desc[bsd_pkg::ReloadHi:bsd_pkg::ReloadLo];
  end
endmodule
`default_nettype wire

/* File: bsd_descriptor.sv */
// Descriptor holder, decoder and retire logic for bulk/control splits
//
// Function
// R1 - Zero reload count disables NAK retirement
// R2 - Software loads reload and NAK count equal
// R3 - Software zeroes reload for split transactions
// R4 - Buffer offset is memory word address
// R5 - Hub address and port from fixed bits
// R6 - Split bit selects translator transaction
// R7 - Endpoint kind: control or bulk
// R8 - Token PID: OUT, IN, SETUP
// R9 - Device address and split endpoint number
// R10 - Max packet size, full-speed at most 64
// R11 - Byte total bounds payload depth
// R12 - Valid cleared on completion or fatal error
// R13 - Speed code selects low or full speed
// R14 - NAK count reaching zero clears valid
// R15 - Hub fields ignored without split
// R16 - Reserved bits ignored and preserved
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module bsd_descriptor #(
  parameter int unsigned NakW = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic [1:0] txnResult,
  input wire logic txnLast,
  output logic descValid,
  output logic txnGo,
  output logic [1:0] tokenPid,
  output logic splitMode,
  output logic lowSpeed,
  output logic [6:0] hubAddr,
  output logic [6:0] hubPortIndex,
  output logic [6:0] devAddr,
  output logic [3:0] endpointNumber,
  output logic [10:0] maxPacketSize,
  output logic [14:0] transferByteTotal,
  output logic [15:0] payloadBufferOffset
);
  ////////////////////////////////////////////////////////////////////
  // Elaboration check: counter width must match the 4-bit field
  if (NakW != 4) begin : g_bad_nak
    $error("NakW must be 4");
  end

  // Engine states, Gray coded along idle-run-retire
  typedef enum logic [1:0] {
    StIdle = 2'h0,
    StRun = 2'h1,
    StDone = 2'h3
  } bsd_st_t;

  // Whole module state in one struct
  typedef struct packed {
    logic [95:0] desc;
    logic [NakW-1:0] nakCount;
    bsd_st_t st;
    logic [31:0] rdata;
    logic fatal;
    logic nakExpired;
    logic txnGo;
    logic [1:0] pid;
    logic split;
    logic low;
    logic [6:0] hub;
    logic [6:0] port;
    logic [6:0] dev;
    logic [3:0] ep;
    logic [10:0] mps;
    logic [14:0] bytes;
    logic [15:0] offs;
  } bsd_state_t;

  bsd_state_t s_q;
  bsd_state_t s_d;
  bsd_pkg::bsd_dec_t dec;
  logic [15:0] convWord;
  logic convIn;

  ////////////////////////////////////////////////////////////////////
  // Field decoder on the stored descriptor
  bsd_field_decode u_dec (
    .desc(s_q.desc),
    .dec(dec)
  );

  // Helper converter so software can translate a processor address
  bsd_addr_conv u_conv (
    .cpuAddr(s_q.desc[bsd_pkg::OffsHi+2:bsd_pkg::OffsLo]),
    .wordAddr(convWord),
    .inWindow(convIn)
  );

  // Descriptor is runnable only with a legal kind, token and size
  logic legal;
  assign legal = dec.kindOk && (dec.pid != bsd_pkg::PidBad) && dec.mpsOk;

  ////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.txnGo = 1'b0;
    s_d.rdata = '0;
    // Register writes; unmapped offsets are ignored
    if (regWr) begin
      case (regAddr)
        bsd_pkg::OffDw0: s_d.desc[31:0] = regWdata;
        bsd_pkg::OffDw1: s_d.desc[63:32] = regWdata;
        // Reload and NAK counter load together from the same field
        bsd_pkg::OffDw2: begin
          s_d.desc[95:64] = regWdata;
          s_d.nakCount = regWdata[28:25];
        end
        bsd_pkg::OffCtrl: begin
          s_d.nakCount = regWdata[NakW-1:0];
          s_d.fatal = 1'b0;
          s_d.nakExpired = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // Register reads, data appear one cycle later
    if (regRd) begin
      case (regAddr)
        bsd_pkg::OffDw0: s_d.rdata = s_q.desc[31:0];
        bsd_pkg::OffDw1: s_d.rdata = s_q.desc[63:32];
        bsd_pkg::OffDw2: s_d.rdata = s_q.desc[95:64];
        bsd_pkg::OffCtrl: s_d.rdata = {28'h0000000, s_q.nakCount};
        bsd_pkg::OffTok: s_d.rdata = {15'h0000, convIn, convWord};
        bsd_pkg::OffStat: s_d.rdata = {26'h0000000, legal, s_q.nakExpired, s_q.fatal,
                                       s_q.st, s_q.desc[bsd_pkg::ValidBit]};
        default: s_d.rdata = '0;
      endcase
    end
    // Engine sequencing
    case (s_q.st)
      StIdle: begin
        if (s_q.desc[bsd_pkg::ValidBit]) begin
          if (legal) begin
            s_d.st = StRun;
            s_d.txnGo = 1'b1;
            s_d.pid = dec.pid;
            s_d.split = dec.split;
            s_d.low = dec.lowSpeed;
            s_d.hub = dec.hubAddr;
            s_d.port = dec.hubPortIndex;
            s_d.dev = dec.devAddr;
            s_d.ep = dec.endpointNumber;
            s_d.mps = dec.maxPacketSize;
            s_d.bytes = dec.transferByteTotal;
            s_d.offs = dec.payloadBufferOffset;
          end else begin
            // R12 illegal is fatal
            s_d.desc[bsd_pkg::ValidBit] = 1'b0;
            s_d.fatal = 1'b1;
          end
        end
      end
      StRun: begin
        case (txnResult)
          // R12 clear on completion
          bsd_pkg::ResAck: if (txnLast) s_d.st = StDone;
          bsd_pkg::ResFatal: begin
            s_d.desc[bsd_pkg::ValidBit] = 1'b0;
            s_d.fatal = 1'b1;
            s_d.st = StIdle;
          end
          bsd_pkg::ResNak: begin
            // R1 zero reload ignores NAKs
            if (dec.reloadCount != 4'h0) begin
              // R14 expiry retires descriptor
              if (s_q.nakCount <= 4'h1) begin
                s_d.nakCount = '0;
                s_d.desc[bsd_pkg::ValidBit] = 1'b0;
                s_d.nakExpired = 1'b1;
                s_d.st = StIdle;
              end else begin
                s_d.nakCount = s_q.nakCount - 4'h1;
              end
            end
          end
          default: begin
          end
        endcase
      end
      StDone: begin
        // R16 only the valid bit is rewritten
        s_d.desc[bsd_pkg::ValidBit] = 1'b0;
        s_d.st = StIdle;
      end
      default: s_d.st = StIdle;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // State register with synchronous reset and clock enable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign regRdata = s_q.rdata;
  assign descValid = s_q.desc[bsd_pkg::ValidBit];
  assign txnGo = s_q.txnGo;
  assign tokenPid = s_q.pid;
  assign splitMode = s_q.split;
  assign lowSpeed = s_q.low;
  assign hubAddr = s_q.hub;
  assign hubPortIndex = s_q.port;
  assign devAddr = s_q.dev;
  assign endpointNumber = s_q.ep;
  assign maxPacketSize = s_q.mps;
  assign transferByteTotal = s_q.bytes;
  assign payloadBufferOffset = s_q.offs;

  ////////////////////////////////////////////////////////////////////
  // Checks
  property p_zero_reload;
    @(posedge clk) disable iff (sys_rst)
      (clkEn && s_q.st == StRun && txnResult == bsd_pkg::ResNak && dec.reloadCount == 4'h0)
      |=> (s_q.nakCount == $past(s_q.nakCount));
  endproperty
  a_zero_reload: assert property (p_zero_reload) else $error("NAK counted with zero reload"); // R1

  property p_nak_expire;
    @(posedge clk) disable iff (sys_rst)
      (clkEn && s_q.st == StRun && txnResult == bsd_pkg::ResNak && dec.reloadCount != 4'h0
       && s_q.nakCount == 4'h1) |=> !descValid;
  endproperty
  a_nak_expire: assert property (p_nak_expire) else $error("Valid kept after NAK expiry"); // R14

  property p_fatal_clear;
    @(posedge clk) disable iff (sys_rst)
      (clkEn && s_q.st == StRun && txnResult == bsd_pkg::ResFatal) |=> !descValid && s_q.fatal;
  endproperty
  a_fatal_clear: assert property (p_fatal_clear) else $error("Valid kept after fatal"); // R12

  property p_done_clear;
    @(posedge clk) disable iff (sys_rst)
      (clkEn && s_q.st == StRun && txnResult == bsd_pkg::ResAck && txnLast) |=> ##1 !descValid;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("Valid kept after completion"); // R12

  property p_split_hub;
    @(posedge clk) disable iff (sys_rst)
      txnGo |-> (splitMode ? (hubAddr == s_q.desc[bsd_pkg::HubHi:bsd_pkg::HubLo])
                           : (hubAddr == 7'h00));
  endproperty
  a_split_hub: assert property (p_split_hub) else $error("Hub address wrong"); // R5

  property p_nosplit_low;
    @(posedge clk) disable iff (sys_rst)
      (txnGo && !splitMode) |-> !lowSpeed && hubPortIndex == 7'h00;
  endproperty
  a_nosplit_low: assert property (p_nosplit_low) else $error("Split fields leaked"); // R15

  property p_token;
    @(posedge clk) disable iff (sys_rst)
      txnGo |-> tokenPid == s_q.desc[bsd_pkg::PidHi:bsd_pkg::PidLo] && tokenPid != 2'h3;
  endproperty
  a_token: assert property (p_token) else $error("Token mismatch"); // R8

  property p_endpoint;
    @(posedge clk) disable iff (sys_rst)
      txnGo |-> endpointNumber == {s_q.desc[34:32], s_q.desc[31]} && devAddr == s_q.desc[41:35];
  endproperty
  a_endpoint: assert property (p_endpoint) else $error("Endpoint or device wrong"); // R9

  property p_fs_mps;
    @(posedge clk) disable iff (sys_rst)
      (txnGo && splitMode && !lowSpeed) |-> maxPacketSize <= 11'h040;
  endproperty
  a_fs_mps: assert property (p_fs_mps) else $error("Full-speed packet too large"); // R10

  property p_bytes;
    @(posedge clk) disable iff (sys_rst)
      txnGo |-> transferByteTotal == s_q.desc[bsd_pkg::BytesHi:bsd_pkg::BytesLo];
  endproperty
  a_bytes: assert property (p_bytes) else $error("Byte total wrong"); // R11

  property p_offset;
    @(posedge clk) disable iff (sys_rst)
      txnGo |-> payloadBufferOffset == s_q.desc[bsd_pkg::OffsHi:bsd_pkg::OffsLo];
  endproperty
  a_offset: assert property (p_offset) else $error("Buffer offset wrong"); // R4

  property p_split_sel;
    @(posedge clk) disable iff (sys_rst)
      txnGo |-> splitMode == s_q.desc[bsd_pkg::SplitBit];
  endproperty
  a_split_sel: assert property (p_split_sel) else $error("Split select wrong"); // R6

  property p_speed;
    @(posedge clk) disable iff (sys_rst)
      (txnGo && splitMode) |->
        lowSpeed == (s_q.desc[bsd_pkg::SpeedHi:bsd_pkg::SpeedLo] == bsd_pkg::SpeedLow);
  endproperty
  a_speed: assert property (p_speed) else $error("Speed code decoded wrong"); // R13
endmodule
`default_nettype wire

/* File: bsd_engine_model.sv */
// Transaction engine stand-in that answers each started descriptor
`timescale 1ns/1ps
`default_nettype none
module bsd_engine_model (
  input wire logic clk,
  input wire logic txnGo,
  input wire logic descValid,
  input wire logic [3:0] mids,
  input wire logic [3:0] naks,
  input wire logic [1:0] endKind,
  input wire logic [3:0] gap,
  output logic [1:0] txnResult,
  output logic txnLast,
  output logic busy
);
  // Loop index over the planned packets
  int k;
  // One outcome, then idle cycles only when a gap is asked for
  task automatic send(input logic [1:0] r, input logic l);
    txnResult <= r;
    txnLast <= l;
    @(posedge clk);
    if (gap != 4'h0) begin
      txnResult <= bsd_pkg::ResNone;
      txnLast <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask
  ////////////////////////////////////////
  // Plays the plan set by the bench; NAKs stop once valid drops
  initial begin
    txnResult = bsd_pkg::ResNone;
    txnLast = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (txnGo === 1'b1) begin
        busy <= 1'b1;
        for (k = 0; k < mids; k++) send(bsd_pkg::ResAck, 1'b0);
        for (k = 0; k < naks && descValid === 1'b1; k++) send(bsd_pkg::ResNak, 1'b0);
        if (endKind != 2'h0) send(endKind, endKind == bsd_pkg::ResAck);
        txnResult <= bsd_pkg::ResNone;
        txnLast <= 1'b0;
        @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test_bulk_split_descriptor_decode.sv */
// Self-checking bench for the split descriptor decoder
`timescale 1ns/1ps
`default_nettype none
module test_bulk_split_descriptor_decode;
  // Bench-driven inputs; clkEn high except for one frozen write
  logic clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, v;
  logic [1:0] txnResult, tokenPid, endKind = 2'h0;
  logic txnLast, descValid, txnGo, splitMode, lowSpeed, busy;
  logic [6:0] hubAddr, hubPortIndex, devAddr;
  logic [3:0] endpointNumber, mids = 4'h0, naks = 4'h0, gap = 4'h0;
  logic [10:0] maxPacketSize;
  logic [14:0] transferByteTotal;
  logic [15:0] payloadBufferOffset, lfsr_q = 16'h40a3;
  int mismatches = 0, samples_checked = 0, i;
  always #10 clk = ~clk;
  bsd_descriptor bsd_descriptor_i (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .txnResult(txnResult), .txnLast(txnLast), .descValid(descValid),
    .txnGo(txnGo), .tokenPid(tokenPid), .splitMode(splitMode), .lowSpeed(lowSpeed),
    .hubAddr(hubAddr), .hubPortIndex(hubPortIndex), .devAddr(devAddr),
    .endpointNumber(endpointNumber), .maxPacketSize(maxPacketSize),
    .transferByteTotal(transferByteTotal), .payloadBufferOffset(payloadBufferOffset));
  bsd_engine_model bsd_engine_model_i (.clk(clk), .txnGo(txnGo), .descValid(descValid),
    .mids(mids), .naks(naks), .endKind(endKind), .gap(gap), .txnResult(txnResult),
    .txnLast(txnLast), .busy(busy));
  ////////////////////////////////////////
  // Pseudo-random source for fields and engine plans
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction
  // Four-state compare so an unknown never matches
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Register port: the write strobe stays up until idle, so writes go back to back
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
  endtask
  task automatic idle();
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    regWr <= 1'b0;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdata;
    @(posedge clk);
  endtask
  // Extra edge after release keeps the first request clear of reset
  task automatic rst();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask
  ////////////////////////////////////////
  // One descriptor: b selects a legal one (0) or a refused variant
  task automatic run(input int n, input int b);
    int mode, rl, ok, w, fin, cpu;
    logic [95:0] d;
    mode = (n / 2) % 3;
    d = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    rl = (mode != 0) ? 0 : rnd() % 8;
    d[45:44] = (n % 2) ? bsd_pkg::KindBulk : bsd_pkg::KindControl;
    d[43:42] = 2'(n % 3);
    d[46] = (mode != 0);
    if (mode == 1) d[49:48] = bsd_pkg::SpeedFull;
    if (mode == 2) d[49:48] = bsd_pkg::SpeedLow;
    if (mode == 1) d[28:18] = (n == 2) ? 11'h040 : 11'(rnd() % 65);
    d[92:89] = 4'(rl);
    d[87:72] = rnd() | 16'h0400;
    d[0] = 1'b1;
    if (b == 1 || b == 2) d[45:44] = 2'(b * 2 - 1);
    if (b == 3) d[43:42] = 2'h3;
    if (b == 4) d[49:46] = 4'h1;
    if (b == 4) d[28:18] = 11'h041;
    mids <= 4'(rnd() % 2);
    naks <= 4'(rnd() % 6);
    w = rnd() % 3;
    endKind <= (w == 2) ? 2'h3 : 2'(w);
    gap <= 4'(rnd() % 3);
    wr(bsd_pkg::OffDw2, d[95:64]);
    wr(bsd_pkg::OffDw1, d[63:32]);
    wr(bsd_pkg::OffDw0, d[31:0]);
    idle();
    ok = 0;
    for (w = 0; w < 8 && ok == 0; w++) begin
      @(negedge clk);
      if (txnGo === 1'b1) ok = 1;
    end
    chk("start", (b == 0), ok);
    if (b == 0) begin
      chk("pid", d[43:42], tokenPid);
      chk("split", d[46], splitMode);
      chk("low", d[46] && d[49:48] == 2'h2, lowSpeed);
      chk("hub", d[46] ? d[63:57] : 7'h0, hubAddr);
      chk("port", d[46] ? d[56:50] : 7'h0, hubPortIndex);
      chk("dev", d[41:35], devAddr);
      chk("ep", {d[34:32], d[31]}, endpointNumber);
      chk("mps", d[28:18], maxPacketSize);
      chk("bytes", d[17:3], transferByteTotal);
      chk("offs", d[87:72], payloadBufferOffset);
      // Busy rises at the next edge; look after it has settled
      @(negedge clk);
      for (w = 0; w < 300 && busy !== 1'b0; w++) @(negedge clk);
      if (w == 300) begin
        mismatches++;
        results();
      end
      repeat (2) @(negedge clk);
      fin = (rl != 0 && naks >= rl) ? 0 : (endKind == 2'h0);
      chk("valid", fin, descValid);
      @(posedge clk);
      rd(bsd_pkg::OffTok, v);
      cpu = d[89:72];
      chk("word", 32'h10000 | ((cpu - 1024) / 8), v);
      // Only the valid bit may have been rewritten by hardware
      rd(bsd_pkg::OffDw0, v);
      chk("dw0", {d[31:1], fin[0]}, v);
      rd(bsd_pkg::OffDw2, v);
      chk("dw2", d[95:64], v);
      rd(bsd_pkg::OffStat, v);
      chk("expired", (rl != 0 && naks >= rl), v[4]);
    end else begin
      @(posedge clk);
      rd(bsd_pkg::OffStat, v);
      chk("fatal", 1, v[3]);
      chk("valid", 0, descValid);
      // Control write clears the sticky outcome flags
      wr(bsd_pkg::OffCtrl, 32'h0);
      idle();
      rd(bsd_pkg::OffStat, v);
      chk("cleared", 0, v[4:3]);
    end
    rst();
  endtask
  ////////////////////////////////////////
  // Main sequence: reset state, legal sweep, refused cases
  initial begin
    rst();
    @(negedge clk);
    chk("valid", 0, descValid);
    chk("go", 0, txnGo);
    @(posedge clk);
    rd(8'h20, v);
    chk("unmapped", 0, v);
    // Clock enable low must freeze a write
    clkEn <= 1'b0;
    wr(bsd_pkg::OffDw0, 32'h1);
    idle();
    clkEn <= 1'b1;
    @(negedge clk);
    chk("frozen", 0, descValid);
    @(posedge clk);
    for (i = 0; i < 12; i++) run(i, 0);
    for (i = 1; i < 5; i++) run(i, i);
    results();
  end
endmodule
`default_nettype wire
